// ===== src/cbm_core.sv
// execution core for bit, move and control operations
`include "cbm_consts.svh"
`default_nettype none
module cbm_core (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic op_valid_in,
    input wire cbm_pkg::cbm_op_t op_in,
    input wire logic [4:0] dst_in,
    input wire logic [4:0] src_in,
    input wire logic [2:0] bit_in,
    input wire logic [7:0] imm_in,
    input wire logic [5:0] disp_in,
    input wire logic [15:0] abs_addr_in,
    input wire cbm_pkg::cbm_ptr_t ptr_sel_in,
    input wire cbm_pkg::cbm_mode_t ptr_mode_in,
    input wire logic [7:0] dm_rdata_in,
    input wire logic [15:0] pm_rdata_in,
    input wire logic debug_resume_in,
    input wire logic [4:0] reg_rd_idx_in,
    output logic op_ready_out,
    output logic [7:0] status_out,
    output logic [15:0] sp_out,
    output logic [15:0] dm_addr_out,
    output logic [7:0] dm_wdata_out,
    output logic dm_we_out,
    output logic dm_re_out,
    output logic [14:0] pm_addr_out,
    output logic pm_re_out,
    output logic sleep_req_out,
    output logic wdt_restart_out,
    output logic break_req_out,
    output logic [7:0] reg_rd_data_out
);
    // low-byte index of a pointer pair
    function automatic logic [4:0] ptr_base(input cbm_pkg::cbm_ptr_t sel);
        logic [4:0] idx;
        idx = `CBM_REG_X;
        if (sel == cbm_pkg::cbm_ptr_y) begin
            idx = `CBM_REG_Y;
        end
        if (sel == cbm_pkg::cbm_ptr_z) begin
            idx = `CBM_REG_Z;
        end
        return idx;
    endfunction

    cbm_exec_if xif ();

    logic [7:0] rf [`CBM_NREGS];
    logic [7:0] status_register;
    logic [15:0] sp;
    cbm_pkg::cbm_state_t state;
    logic [1:0] wait_cnt;
    logic [4:0] dst_q;
    logic load_q;
    logic byte_hi_q;

    logic take;
    logic finish;
    logic is_ind_ld;
    logic is_ind_st;
    logic is_off;
    logic is_abs;
    logic is_pm;
    logic is_push;
    logic is_pop;
    logic is_dload;
    logic is_dstore;
    logic is_dmem;
    logic alu_wr;
    cbm_pkg::cbm_ptr_t ptr_eff;
    logic [4:0] ptr_idx;
    logic [15:0] ptr_val;
    logic [15:0] sp_inc;
    logic [15:0] sp_dec;
    logic [15:0] next_dm_addr;
    logic [7:0] pm_byte;
    logic [4:0] pair_dst;
    logic [4:0] pair_src;
    logic ptr_upd;
    logic wa_en;
    logic [4:0] wa_idx;
    logic [7:0] wa_data;
    logic wp_en;
    logic [3:0] wp_idx;
    logic [15:0] wp_data;

    // handshake: one op accepted per idle cycle
    assign op_ready_out = (state == cbm_st_idle_w());
    assign take = op_valid_in & op_ready_out;
    assign finish = ((state == cbm_pkg::cbm_st_dmem) || (state == cbm_pkg::cbm_st_pmem)) &&
        (wait_cnt == 2'h0);

    function automatic cbm_pkg::cbm_state_t cbm_st_idle_w();
        return cbm_pkg::cbm_st_idle;
    endfunction

    // operation classes
    assign is_ind_ld = (op_in == cbm_pkg::indirect_load_op);
    assign is_ind_st = (op_in == cbm_pkg::indirect_store_op);
    assign is_off = (op_in == cbm_pkg::offset_load_op) || (op_in == cbm_pkg::offset_store_op);
    assign is_abs = (op_in == cbm_pkg::absolute_load_op) ||
        (op_in == cbm_pkg::absolute_store_op);
    assign is_pm = (op_in == cbm_pkg::code_memory_read_op) ||
        (op_in == cbm_pkg::code_memory_read_r0_op);
    assign is_push = (op_in == cbm_pkg::stack_push_op);
    assign is_pop = (op_in == cbm_pkg::stack_pop_op);
    assign is_dload = is_ind_ld || is_pop || (op_in == cbm_pkg::offset_load_op) ||
        (op_in == cbm_pkg::absolute_load_op);
    assign is_dstore = is_ind_st || is_push || (op_in == cbm_pkg::offset_store_op) ||
        (op_in == cbm_pkg::absolute_store_op);
    assign is_dmem = is_dload || is_dstore;
    // ops whose result comes back through the shifter
    assign alu_wr = (op_in == cbm_pkg::rotate_right_carry_op) ||
        (op_in == cbm_pkg::arith_shift_right_op) || (op_in == cbm_pkg::nibble_swap_op) ||
        (op_in == cbm_pkg::transfer_flag_to_bit_op);

    // pointer selection; offset forms cannot use X, so X falls back to Y
    assign ptr_eff = is_pm ? cbm_pkg::cbm_ptr_z :
        (is_off && (ptr_sel_in == cbm_pkg::cbm_ptr_x)) ? cbm_pkg::cbm_ptr_y : ptr_sel_in;
    assign ptr_idx = ptr_base(ptr_eff);
    assign ptr_val = {rf[ptr_idx | 5'h01], rf[ptr_idx]};

    // shifter and flag unit
    assign xif.alu_op = op_in;
    assign xif.alu_a = rf[alu_wr ? dst_in : src_in];
    assign xif.alu_status_register = status_register;
    assign xif.alu_bit = bit_in;
    cbm_alu u_alu (
        .bus(xif.alu)
    );

    // address generator; displacement forms never move the pointer
    assign xif.ag_ptr = ptr_val;
    assign xif.ag_use_disp = is_off;
    assign xif.ag_disp = disp_in;
    assign xif.ag_mode = (is_pm && (ptr_mode_in == cbm_pkg::cbm_mode_pre_dec)) ?
        cbm_pkg::cbm_mode_plain : (op_in == cbm_pkg::code_memory_read_r0_op) ?
        cbm_pkg::cbm_mode_plain : ptr_mode_in;
    cbm_agen u_agen (
        .bus(xif.agen)
    );

    // stack grows down: push writes then decrements
    assign sp_inc = sp + 16'h0001;
    assign sp_dec = sp - 16'h0001;
    assign next_dm_addr = is_abs ? abs_addr_in :
        is_push ? sp :
        is_pop ? sp_inc :
        xif.ag_addr;

    // code memory is word wide, Z bit 0 picks the byte
    assign pm_byte = byte_hi_q ? pm_rdata_in[15:8] : pm_rdata_in[7:0];

    // pair copy works on even-aligned register pairs
    assign pair_dst = {dst_in[4:1], 1'b0};
    assign pair_src = {src_in[4:1], 1'b0};

    // pointer write-back on the accept edge
    assign ptr_upd = take && (is_ind_ld || is_ind_st || is_pm) &&
        (xif.ag_ptr_next != ptr_val);

    // byte write port: single-cycle results on accept, loads on finish
    assign wa_en = (take && (alu_wr || (op_in == cbm_pkg::register_copy_op) ||
        (op_in == cbm_pkg::immediate_load_op))) || (finish && load_q);
    assign wa_idx = finish ? dst_q : dst_in;
    assign wa_data = (finish && (state == cbm_pkg::cbm_st_pmem)) ? pm_byte :
        finish ? dm_rdata_in :
        alu_wr ? xif.alu_res :
        (op_in == cbm_pkg::immediate_load_op) ? imm_in : rf[src_in];

    // pair write port: word copy or pointer update
    assign wp_en = (take && (op_in == cbm_pkg::register_pair_copy_op)) || ptr_upd;
    assign wp_idx = ptr_upd ? ptr_idx[4:1] : pair_dst[4:1];
    assign wp_data = ptr_upd ? xif.ag_ptr_next : {rf[pair_src | 5'h01], rf[pair_src]};

    // register file; the pair port wins if both hit the same byte
    genvar gi;
    generate
        for (gi = 0; gi < `CBM_NREGS; gi++) begin : g_rf
            logic hit_p;
            logic hit_a;
            assign hit_p = wp_en && (wp_idx == 4'(gi >> 1));
            assign hit_a = wa_en && (wa_idx == 5'(gi));
            always_ff @(posedge sys_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    rf[gi] <= `CBM_RF_RESET;
                end else if (hit_p) begin
                    rf[gi] <= ((gi % 2) == 1) ? wp_data[15:8] : wp_data[7:0];
                end else if (hit_a) begin
                    rf[gi] <= wa_data;
                end
            end
        end
    endgenerate

    // status changes only through the flag unit on accept;
    // other ops return it unchanged
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_register <= `CBM_STATUS_REGISTER_RESET;
        end else if (take) begin
            status_register <= xif.alu_status_register_next;
        end
    end

    // stack pointer
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sp <= `CBM_SP_RESET;
        end else if (take && is_push) begin
            sp <= sp_dec;
        end else if (take && is_pop) begin
            sp <= sp_inc;
        end
    end

    // sequencer: data ops hold one extra cycle, code reads two
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= cbm_pkg::cbm_st_idle;
            wait_cnt <= `CBM_WAIT_DM;
        end else begin
            unique case (state)
                cbm_pkg::cbm_st_idle: begin
                    if (take && is_dmem) begin
                        state <= cbm_pkg::cbm_st_dmem;
                        wait_cnt <= `CBM_WAIT_DM;
                    end else if (take && is_pm) begin
                        state <= cbm_pkg::cbm_st_pmem;
                        wait_cnt <= `CBM_WAIT_PM;
                    end else if (take && (op_in == cbm_pkg::debug_break_op)) begin
                        state <= cbm_pkg::cbm_st_halt;
                    end
                end
                cbm_pkg::cbm_st_dmem, cbm_pkg::cbm_st_pmem: begin
                    if (finish) begin
                        state <= cbm_pkg::cbm_st_idle;
                    end else begin
                        wait_cnt <= wait_cnt - 2'h1;
                    end
                end
                cbm_pkg::cbm_st_halt: begin
                    if (debug_resume_in) begin
                        state <= cbm_pkg::cbm_st_idle;
                    end
                end
                default: state <= cbm_pkg::cbm_st_idle;
            endcase
        end
    end

    // destination and byte select captured on accept
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dst_q <= `CBM_REG_R0;
            load_q <= 1'b0;
            byte_hi_q <= 1'b0;
        end else if (take) begin
            dst_q <= (op_in == cbm_pkg::code_memory_read_r0_op) ? `CBM_REG_R0 : dst_in;
            load_q <= is_dload || is_pm;
            byte_hi_q <= ptr_val[0];
        end else if (finish) begin
            load_q <= 1'b0;
        end
    end

    // data strobes stand for the one access cycle
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dm_addr_out <= 16'h0000;
            dm_wdata_out <= 8'h00;
            dm_we_out <= 1'b0;
            dm_re_out <= 1'b0;
        end else if (take && is_dmem) begin
            dm_addr_out <= next_dm_addr;
            dm_wdata_out <= rf[src_in];
            dm_we_out <= is_dstore;
            dm_re_out <= is_dload;
        end else if (finish) begin
            dm_we_out <= 1'b0;
            dm_re_out <= 1'b0;
        end
    end

    // code read stands both wait cycles; flash may need one to answer
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pm_addr_out <= 15'h0000;
            pm_re_out <= 1'b0;
        end else if (take && is_pm) begin
            pm_addr_out <= ptr_val[15:1];
            pm_re_out <= 1'b1;
        end else if (finish) begin
            pm_re_out <= 1'b0;
        end
    end

    // one-cycle control pulses
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sleep_req_out <= 1'b0;
            wdt_restart_out <= 1'b0;
            break_req_out <= 1'b0;
        end else begin
            sleep_req_out <= take && (op_in == cbm_pkg::sleep_op);
            wdt_restart_out <= take && (op_in == cbm_pkg::watchdog_restart_op);
            break_req_out <= take && (op_in == cbm_pkg::debug_break_op);
        end
    end

    // observation port, registered so it cannot glitch
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rd_data_out <= 8'h00;
        end else begin
            reg_rd_data_out <= rf[reg_rd_idx_in];
        end
    end

    assign status_out = status_register;
    assign sp_out = sp;
endmodule
`default_nettype wire

// ===== src/cbm_consts.svh
// constants of the execution block
`ifndef CBM_CONSTS_SVH
`define CBM_CONSTS_SVH
// status register bit positions
`define CBM_FLAG_C 3'h0
`define CBM_FLAG_Z 3'h1
`define CBM_FLAG_N 3'h2
`define CBM_FLAG_V 3'h3
`define CBM_FLAG_S 3'h4
`define CBM_FLAG_H 3'h5
`define CBM_FLAG_T 3'h6
`define CBM_FLAG_I 3'h7
// reset values
`define CBM_STATUS_REGISTER_RESET 8'h00
`define CBM_RF_RESET 8'h00
`define CBM_SP_RESET 16'h01FF
// pointer pair low bytes and implicit destination
`define CBM_REG_X 5'h1A
`define CBM_REG_Y 5'h1C
`define CBM_REG_Z 5'h1E
`define CBM_REG_R0 5'h00
`define CBM_NREGS 32
// wait counter preloads
`define CBM_WAIT_DM 2'h0
`define CBM_WAIT_PM 2'h1
`endif

// ===== src/cbm_pkg.sv
// types of the execution block
`default_nettype none
package cbm_pkg;
    typedef enum logic [5:0] {
        nop_op, rotate_right_carry_op, arith_shift_right_op, nibble_swap_op,
        flag_set_op, flag_clear_op, bit_to_transfer_flag_op, transfer_flag_to_bit_op,
        overflow_flag_set_op, overflow_flag_clear_op, half_carry_set_op,
        half_carry_clear_op, signed_flag_set_op, signed_flag_clear_op,
        irq_global_on_op, irq_global_off_op, register_copy_op, register_pair_copy_op,
        immediate_load_op, indirect_load_op, offset_load_op, indirect_store_op,
        offset_store_op, absolute_load_op, absolute_store_op, code_memory_read_op,
        code_memory_read_r0_op, stack_push_op, stack_pop_op, sleep_op,
        watchdog_restart_op, debug_break_op
    } cbm_op_t;
    typedef enum logic [1:0] {cbm_ptr_x, cbm_ptr_y, cbm_ptr_z} cbm_ptr_t;
    typedef enum logic [1:0] {cbm_mode_plain, cbm_mode_post_inc, cbm_mode_pre_dec} cbm_mode_t;
    typedef enum logic [1:0] {cbm_st_idle, cbm_st_dmem, cbm_st_pmem, cbm_st_halt} cbm_state_t;
endpackage
`default_nettype wire

// ===== src/cbm_exec_if.sv
// core to shifter and address generator signals
`default_nettype none
interface cbm_exec_if;
    cbm_pkg::cbm_op_t alu_op;
    logic [7:0] alu_a;
    logic [7:0] alu_status_register;
    logic [2:0] alu_bit;
    logic [7:0] alu_res;
    logic [7:0] alu_status_register_next;
    logic [15:0] ag_ptr;
    cbm_pkg::cbm_mode_t ag_mode;
    logic ag_use_disp;
    logic [5:0] ag_disp;
    logic [15:0] ag_addr;
    logic [15:0] ag_ptr_next;
    modport core (output alu_op, alu_a, alu_status_register, alu_bit, ag_ptr, ag_mode, ag_use_disp,
        ag_disp, input alu_res, alu_status_register_next, ag_addr, ag_ptr_next);
    modport alu (input alu_op, alu_a, alu_status_register, alu_bit, output alu_res, alu_status_register_next);
    modport agen (input ag_ptr, ag_mode, ag_use_disp, ag_disp, output ag_addr, ag_ptr_next);
endinterface
`default_nettype wire

// ===== src/cbm_alu.sv
// shifter, bit transfer and status flag logic
`include "cbm_consts.svh"
`default_nettype none
module cbm_alu (
    cbm_exec_if.alu bus
);
    logic [7:0] res;
    logic [7:0] sn;
    logic shift_op;
    // ror and asr share the flag update
    assign shift_op = (bus.alu_op == cbm_pkg::rotate_right_carry_op) ||
        (bus.alu_op == cbm_pkg::arith_shift_right_op);
    // flags not named by an op pass through unchanged
    always_comb begin
        res = bus.alu_a;
        sn = bus.alu_status_register;
        unique case (bus.alu_op)
            cbm_pkg::rotate_right_carry_op: res = {bus.alu_status_register[`CBM_FLAG_C], bus.alu_a[7:1]};
            cbm_pkg::arith_shift_right_op: res = {bus.alu_a[7], bus.alu_a[7:1]};
            cbm_pkg::nibble_swap_op: res = {bus.alu_a[3:0], bus.alu_a[7:4]};
            cbm_pkg::bit_to_transfer_flag_op: sn[`CBM_FLAG_T] = bus.alu_a[bus.alu_bit];
            cbm_pkg::transfer_flag_to_bit_op: res[bus.alu_bit] = bus.alu_status_register[`CBM_FLAG_T];
            cbm_pkg::flag_set_op: sn[bus.alu_bit] = 1'b1;
            cbm_pkg::flag_clear_op: sn[bus.alu_bit] = 1'b0;
            cbm_pkg::overflow_flag_set_op: sn[`CBM_FLAG_V] = 1'b1;
            cbm_pkg::overflow_flag_clear_op: sn[`CBM_FLAG_V] = 1'b0;
            cbm_pkg::half_carry_set_op: sn[`CBM_FLAG_H] = 1'b1;
            cbm_pkg::half_carry_clear_op: sn[`CBM_FLAG_H] = 1'b0;
            cbm_pkg::signed_flag_set_op: sn[`CBM_FLAG_S] = 1'b1;
            cbm_pkg::signed_flag_clear_op: sn[`CBM_FLAG_S] = 1'b0;
            cbm_pkg::irq_global_on_op: sn[`CBM_FLAG_I] = 1'b1;
            cbm_pkg::irq_global_off_op: sn[`CBM_FLAG_I] = 1'b0;
            default: ;
        endcase
        if (shift_op) begin
            sn[`CBM_FLAG_C] = bus.alu_a[0];
            sn[`CBM_FLAG_N] = res[7];
            sn[`CBM_FLAG_Z] = (res == 8'h00);
            sn[`CBM_FLAG_V] = res[7] ^ bus.alu_a[0];
        end
    end
    assign bus.alu_res = res;
    assign bus.alu_status_register_next = sn;
endmodule
`default_nettype wire

// ===== src/cbm_agen.sv
// pointer address generator
`default_nettype none
module cbm_agen (
    cbm_exec_if.agen bus
);
    logic [15:0] inc;
    logic [15:0] dec;
    logic [15:0] disp_sum;
    assign inc = bus.ag_ptr + 16'h0001;
    assign dec = bus.ag_ptr - 16'h0001;
    assign disp_sum = bus.ag_ptr + {10'h000, bus.ag_disp};
    // pre-decrement uses the new value, post-increment the old one
    assign bus.ag_addr = bus.ag_use_disp ? disp_sum :
        (bus.ag_mode == cbm_pkg::cbm_mode_pre_dec) ? dec : bus.ag_ptr;
    assign bus.ag_ptr_next = bus.ag_use_disp ? bus.ag_ptr :
        (bus.ag_mode == cbm_pkg::cbm_mode_post_inc) ? inc :
        (bus.ag_mode == cbm_pkg::cbm_mode_pre_dec) ? dec : bus.ag_ptr;
endmodule
`default_nettype wire

// ===== sim/cbm_mem_model.sv
// data and code memory model
`default_nettype none
module cbm_mem_model (
    input wire logic sys_clk_in,
    input wire logic [15:0] dm_addr_in,
    input wire logic [7:0] dm_wdata_in,
    input wire logic dm_we_in,
    input wire logic dm_re_in,
    input wire logic [14:0] pm_addr_in,
    input wire logic pm_re_in,
    output logic [7:0] dm_rdata_out,
    output logic [15:0] pm_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    logic [15:0] pm_word;
    // code word follows the address one cycle late
    always_ff @(posedge sys_clk_in) begin
        if (dm_we_in) begin
            mem[dm_addr_in[7:0]] <= dm_wdata_in;
        end
        if (pm_re_in) begin
            pm_word <= {~pm_addr_in[7:0], pm_addr_in[7:0]};
        end
    end
    // unread lines show inverted data to catch stale reads
    assign dm_rdata_out = dm_re_in ? mem[dm_addr_in[7:0]] : ~mem[dm_addr_in[7:0]];
    assign pm_rdata_out = pm_re_in ? pm_word : ~pm_word;
endmodule
`default_nettype wire

// ===== sim/cbm_core_assertions.sv
// concurrent checks on the core's ports
`default_nettype none
module cbm_core_assertions (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic op_valid_in,
    input wire cbm_pkg::cbm_op_t op_in,
    input wire logic op_ready_out,
    input wire logic [7:0] status_out,
    input wire logic [15:0] sp_out,
    input wire logic [15:0] dm_addr_out,
    input wire logic dm_we_out,
    input wire logic pm_re_out,
    input wire logic sleep_req_out,
    input wire logic wdt_restart_out,
    input wire logic break_req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire acc = op_valid_in && op_ready_out;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    // data memory ops stall one cycle, flags kept
    a_data_two_cycle: assert property (
        acc && op_in inside {[cbm_pkg::indirect_load_op:cbm_pkg::absolute_store_op],
        cbm_pkg::stack_push_op, cbm_pkg::stack_pop_op}
        |=> !op_ready_out && $stable(status_out) ##1 op_ready_out)
        else $error("data op not two cycles");
    a_code_three: assert property (
        acc && op_in inside {cbm_pkg::code_memory_read_op, cbm_pkg::code_memory_read_r0_op}
        |=> pm_re_out [*2] ##1 !pm_re_out && op_ready_out)
        else $error("code read not three cycles");
    a_single_ready: assert property (
        acc && op_in inside {[cbm_pkg::rotate_right_carry_op:cbm_pkg::immediate_load_op]}
        |=> op_ready_out) else $error("single-cycle op stalled");
    // flag ops touch exactly one bit
    a_ovf_set_only: assert property (
        acc && op_in == cbm_pkg::overflow_flag_set_op
        |=> status_out == ($past(status_out) | 8'h08)) else $error("overflow set wrong");
    a_signed_clear_only: assert property (
        acc && op_in == cbm_pkg::signed_flag_clear_op
        |=> status_out == ($past(status_out) & 8'hEF)) else $error("signed clear wrong");
    a_sleep_pulse: assert property (
        acc && op_in == cbm_pkg::sleep_op |=> sleep_req_out && op_ready_out)
        else $error("sleep request missing");
    a_wdt_pulse: assert property (
        acc && op_in == cbm_pkg::watchdog_restart_op |=> wdt_restart_out && $stable(status_out))
        else $error("restart missing");
    a_push_stack: assert property (
        acc && op_in == cbm_pkg::stack_push_op |=> dm_we_out
        && dm_addr_out == $past(sp_out) && sp_out == $past(sp_out) - 16'h0001)
        else $error("push wrong");
    a_break_halt: assert property (
        acc && op_in == cbm_pkg::debug_break_op |=> break_req_out && !op_ready_out)
        else $error("break did not halt");
    cover property (acc && op_in == cbm_pkg::stack_pop_op);
    cover property (acc && op_in == cbm_pkg::code_memory_read_op);
    cover property (acc && op_in == cbm_pkg::debug_break_op);
endmodule
`default_nettype wire

// ===== sim/cbm_core_tb.sv
// self-checking bench for the execution core
`default_nettype none
module cbm_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0, resetn_in = 1'b0, op_valid_in = 1'b0, debug_resume_in = 1'b0;
    cbm_pkg::cbm_op_t op_in = cbm_pkg::nop_op;
    cbm_pkg::cbm_ptr_t ptr_sel_in = cbm_pkg::cbm_ptr_x;
    cbm_pkg::cbm_mode_t ptr_mode_in = cbm_pkg::cbm_mode_plain;
    logic [4:0] dst_in = 5'h00, src_in = 5'h00, reg_rd_idx_in = 5'h00;
    logic [2:0] bit_in = 3'h0;
    logic [7:0] imm_in = 8'h00;
    logic [5:0] disp_in = 6'h00;
    logic [15:0] abs_addr_in = 16'h0000;
    logic [7:0] dm_rdata_in, status_out, dm_wdata_out, reg_rd_data_out, sr;
    logic [15:0] pm_rdata_in, sp_out, dm_addr_out;
    logic [14:0] pm_addr_out;
    logic op_ready_out, dm_we_out, dm_re_out, pm_re_out;
    logic sleep_req_out, wdt_restart_out, break_req_out;
    int err_total = 0;
    int n_checks = 0;

    cbm_core dut (.sys_clk_in, .resetn_in, .op_valid_in, .op_in, .dst_in, .src_in, .bit_in,
        .imm_in, .disp_in, .abs_addr_in, .ptr_sel_in, .ptr_mode_in, .dm_rdata_in, .pm_rdata_in,
        .debug_resume_in, .reg_rd_idx_in, .op_ready_out, .status_out, .sp_out, .dm_addr_out,
        .dm_wdata_out, .dm_we_out, .dm_re_out, .pm_addr_out, .pm_re_out, .sleep_req_out,
        .wdt_restart_out, .break_req_out, .reg_rd_data_out);
    cbm_mem_model mem (.sys_clk_in, .dm_addr_in(dm_addr_out), .dm_wdata_in(dm_wdata_out),
        .dm_we_in(dm_we_out), .dm_re_in(dm_re_out), .pm_addr_in(pm_addr_out),
        .pm_re_in(pm_re_out), .dm_rdata_out(dm_rdata_in), .pm_rdata_out(pm_rdata_in));

    // 20 MHz core clock
    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    // k: immediate, bit index, displacement and low address byte
    task run(cbm_pkg::cbm_op_t o, logic [4:0] d, logic [4:0] s, logic [7:0] k,
        cbm_pkg::cbm_mode_t m = cbm_pkg::cbm_mode_plain, cbm_pkg::cbm_ptr_t p = cbm_pkg::cbm_ptr_x);
        op_in <= o;
        dst_in <= d;
        src_in <= s;
        imm_in <= k;
        bit_in <= k[2:0];
        disp_in <= k[5:0];
        abs_addr_in <= {8'h00, k};
        ptr_sel_in <= p;
        ptr_mode_in <= m;
        op_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        op_valid_in <= 1'b0;
        // bounded wait: a hung core ends the run
        for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk_in);
            if (op_ready_out === 1'b1) begin
                break;
            end
            if (i == 11) begin
                err_total++;
                wrap_up();
            end
        end
        @(posedge sys_clk_in);
    endtask

    task load_imm(logic [4:0] d, logic [7:0] k);
        run(cbm_pkg::immediate_load_op, d, 5'h00, k);
    endtask

    task chk_sr;
        chk("status", 16'(sr), 16'(status_out));
    endtask

    task rd(logic [4:0] idx, logic [7:0] e);
        reg_rd_idx_in <= idx;
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk("register", 16'(e), 16'(reg_rd_data_out));
        @(posedge sys_clk_in);
    endtask

    task t_shift;
        load_imm(5'h10, 8'h81);
        load_imm(5'h11, 8'h81);
        run(cbm_pkg::arith_shift_right_op, 5'h11, 5'h11, 8'h00);
        rd(5'h11, 8'hC0);
        chk("carry", 16'h0001, 16'(status_out[0]));
        run(cbm_pkg::flag_set_op, 5'h00, 5'h00, 8'h00);
        run(cbm_pkg::rotate_right_carry_op, 5'h10, 5'h10, 8'h00);
        rd(5'h10, 8'hC0);
        chk("status", 16'h0005, 16'(status_out));
        run(cbm_pkg::flag_clear_op, 5'h00, 5'h00, 8'h02);
        sr = 8'h01;
        load_imm(5'h12, 8'h3C);
        run(cbm_pkg::nibble_swap_op, 5'h12, 5'h12, 8'h00);
        rd(5'h12, 8'hC3);
        run(cbm_pkg::register_copy_op, 5'h13, 5'h10, 8'h00);
        run(cbm_pkg::register_pair_copy_op, 5'h14, 5'h12, 8'h00);
        rd(5'h15, 8'hC0);
        chk_sr();
    endtask

    task t_bits;
        run(cbm_pkg::bit_to_transfer_flag_op, 5'h00, 5'h10, 8'h06);
        sr = 8'h41;
        chk_sr();
        run(cbm_pkg::transfer_flag_to_bit_op, 5'h16, 5'h00, 8'h03);
        rd(5'h16, 8'h08);
        chk_sr();
    endtask

    // set then clear V, H, S and I
    task t_flags;
        logic [7:0] m;
        for (int i = 8; i < 16; i++) begin
            m = (i < 10) ? 8'h08 : (i < 12) ? 8'h20 : (i < 14) ? 8'h10 : 8'h80;
            sr = i[0] ? (sr & ~m) : (sr | m);
            run(cbm_pkg::cbm_op_t'(i), 5'h00, 5'h00, 8'h00);
            chk_sr();
        end
    endtask

    task t_indirect;
        load_imm(5'h1A, 8'h10);
        run(cbm_pkg::indirect_store_op, 5'h00, 5'h10, 8'h00, cbm_pkg::cbm_mode_post_inc);
        rd(5'h1A, 8'h11);
        run(cbm_pkg::indirect_load_op, 5'h17, 5'h00, 8'h00, cbm_pkg::cbm_mode_pre_dec);
        rd(5'h17, 8'hC0);
        run(cbm_pkg::indirect_load_op, 5'h18, 5'h00, 8'h00, cbm_pkg::cbm_mode_post_inc);
        rd(5'h18, 8'hC0);
        rd(5'h1A, 8'h11);
        run(cbm_pkg::indirect_store_op, 5'h00, 5'h16, 8'h00, cbm_pkg::cbm_mode_pre_dec);
        run(cbm_pkg::indirect_load_op, 5'h19, 5'h00, 8'h00);
        rd(5'h19, 8'h08);
        chk_sr();
    endtask

    task t_offset_abs;
        load_imm(5'h1C, 8'h20);
        run(cbm_pkg::offset_store_op, 5'h00, 5'h12, 8'h05, .p(cbm_pkg::cbm_ptr_y));
        run(cbm_pkg::offset_load_op, 5'h18, 5'h00, 8'h05, .p(cbm_pkg::cbm_ptr_y));
        rd(5'h18, 8'hC3);
        rd(5'h1C, 8'h20);
        run(cbm_pkg::absolute_store_op, 5'h00, 5'h16, 8'h40);
        run(cbm_pkg::absolute_load_op, 5'h01, 5'h00, 8'h40);
        rd(5'h01, 8'h08);
    endtask

    task t_stack;
        run(cbm_pkg::stack_push_op, 5'h00, 5'h12, 8'h00);
        chk("sp", 16'h01FE, sp_out);
        run(cbm_pkg::stack_pop_op, 5'h02, 5'h00, 8'h00);
        chk("sp", 16'h01FF, sp_out);
        rd(5'h02, 8'hC3);
        chk_sr();
    endtask

    // odd Z picks the high byte of the word
    task t_code;
        load_imm(5'h1E, 8'h05);
        run(cbm_pkg::code_memory_read_op, 5'h03, 5'h00, 8'h00, cbm_pkg::cbm_mode_post_inc);
        rd(5'h03, 8'hFD);
        rd(5'h1E, 8'h06);
        run(cbm_pkg::code_memory_read_r0_op, 5'h07, 5'h00, 8'h00);
        rd(5'h00, 8'h03);
    endtask

    task t_ctrl;
        run(cbm_pkg::sleep_op, 5'h00, 5'h00, 8'h00);
        chk_sr();
        run(cbm_pkg::watchdog_restart_op, 5'h00, 5'h00, 8'h00);
        chk_sr();
        op_in <= cbm_pkg::debug_break_op;
        op_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        op_valid_in <= 1'b0;
        repeat (3) @(negedge sys_clk_in);
        chk("ready", 16'h0000, 16'(op_ready_out));
        @(posedge sys_clk_in);
        debug_resume_in <= 1'b1;
        @(posedge sys_clk_in);
        debug_resume_in <= 1'b0;
        run(cbm_pkg::nop_op, 5'h00, 5'h00, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        chk("sp", 16'h01FF, sp_out);
        chk("status", 16'h0000, 16'(status_out));
        t_shift();
        t_bits();
        t_flags();
        t_indirect();
        t_offset_abs();
        t_stack();
        t_code();
        t_ctrl();
        wrap_up();
    end
endmodule

bind cbm_core cbm_core_assertions chk (.sys_clk_in, .resetn_in, .op_valid_in, .op_in,
    .op_ready_out, .status_out, .sp_out, .dm_addr_out, .dm_we_out, .pm_re_out,
    .sleep_req_out, .wdt_restart_out, .break_req_out);
`default_nettype wire
